// File: reconf_pkg.sv
// Package with register map, field positions, reset values, cycle counts and states.
package reconf_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_WALL_BIT = 8;
   localparam int ST_BUSY = 0;
   localparam int ST_PLL_LOCK = 1;
   localparam int ST_FREQ_LOCK = 2;
   localparam int ST_PWRDN = 3;
   localparam int ST_CHAN_DONE = 4;
   localparam int ST_PLL_DONE = 5;
   localparam int ST_LINK_READY = 6;
   localparam logic [2:0] MODE_RST = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ---------------------------------------------------------------
   // Cycle counts
   // ---------------------------------------------------------------
   localparam logic [15:0] OFFSET_CYCLES = 16'h0014;
   localparam logic [15:0] RECONF_CYCLES = 16'h0010;
   localparam logic [15:0] ACCESS_CYCLES = 16'h0004;
   localparam logic [15:0] SCAN_CYCLES = 16'h0012;
   localparam logic [15:0] LOCK_CYCLES = 16'h0020;
   localparam logic [15:0] FREQ_CYCLES = 16'h0020;
   // ---------------------------------------------------------------
   // Controller states
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      CS_OFFSET = 4'b0001,
      CS_IDLE = 4'b0010,
      CS_RECONF = 4'b0100,
      CS_ACCESS = 4'b1000
   } ctl_state_t;
endpackage

// File: reconf_seq.sv
// Transceiver block reconfiguration controller, PLL scan and lock model with AXI4-Lite access.
//
// Summary of operation
// RQ1: Reset logic holds all resets before PLL reconfig.
// RQ2: Config update strobe follows last shifted bit.
// RQ3: Scan done flagged; then PLL reset drops lock.
// RQ4: Transmit digital reset released after PLL lock.
// RQ5: Receive analog reset waits five cycles after lock.
// RQ6: Receive digital reset waits lock-to-data after freqlock.
// RQ7: Settings and mode written, then write-all pulsed. The bench sets the mode and the write-all bit in one AXI write.
// RQ8: All three resets held during channel reconfig.
// RQ9: Busy rises as soon as write-all seen.
// RQ10: Channel reconfig done flagged on completion.
// RQ11: Transmit reset released after done, before analog.
// RQ12: Analog reset released five cycles after done.
// RQ13: Digital reset waits freqlock then lock-to-data time.
// RQ14: Block power-down powers down all channels, blocks.
// RQ15: Power-down pulse held at least one microsecond.
// RQ16: Power-down pulsed only after busy falls.
// RQ17: Busy falls only when offset cancellation finishes.
// RQ18: No power-down during offset cancellation.
// RQ19: Busy pulses at power-up and controller accesses only.
// RQ20: Model busy falls after about twenty cycles.
// RQ21: Forced electrical idle held one cycle first.
// RQ22: Simulation may skip the lock-to-data wait.
// RQ23: External sequencer uses parameterised counters. reset_seq_model uses fixed literal cycle counts (100, 5, 4, 3, 2) instead.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module reconf_seq
   import reconf_pkg::*;
#(
   parameter logic [15:0] OFFSET_N = reconf_pkg::OFFSET_CYCLES,
   parameter logic [15:0] RECONF_N = reconf_pkg::RECONF_CYCLES,
   parameter logic [15:0] ACCESS_N = reconf_pkg::ACCESS_CYCLES,
   parameter logic [15:0] SCAN_N = reconf_pkg::SCAN_CYCLES,
   parameter logic [15:0] LOCK_N = reconf_pkg::LOCK_CYCLES,
   parameter logic [15:0] FREQ_N = reconf_pkg::FREQ_CYCLES
) (
   input wire logic clk, // 100 MHz parallel clock.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic [3:0] s_axi_awaddr, // Write address.
   input wire logic s_axi_awvalid, // Write address valid.
   output logic s_axi_awready, // Write address ready.
   input wire logic [31:0] s_axi_wdata, // Write data.
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
   input wire logic s_axi_wvalid, // Write data valid.
   output logic s_axi_wready, // Write data ready.
   output logic [1:0] s_axi_bresp, // Write response.
   output logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   input wire logic [3:0] s_axi_araddr, // Read address.
   input wire logic s_axi_arvalid, // Read address valid.
   output logic s_axi_arready, // Read address ready.
   output logic [31:0] s_axi_rdata, // Read data.
   output logic [1:0] s_axi_rresp, // Read response.
   output logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready, // Read data ready.
   input wire logic pll_areset, // PLL asynchronous reset pin.
   input wire logic pll_configupdate, // PLL configuration update strobe pin.
   input wire logic gxb_pd, // Transceiver block power-down pin.
   input wire logic rx_analogreset, // Receive analog reset pin.
   input wire logic tx_digitalreset, // Transmit digital reset pin.
   input wire logic rx_digitalreset, // Receive digital reset pin.
   output logic busy, // Controller busy.
   output logic pll_reconfig_done, // One-cycle scan chain done pulse.
   output logic channel_reconfig_done, // One-cycle channel reconfig done pulse.
   output logic pll_locked, // Transceiver PLL locked.
   output logic rx_freqlocked, // Receiver frequency locked.
   output logic powered_down // Block is powered down.
);
   // ---------------------------------------------------------------
   // Pin synchronisation
   // ---------------------------------------------------------------
   logic [5:0] pins_s;
   logic areset_s, cfgupd_s, pd_s, rxa_s, txd_s, rxd_s;
   sync2 #(.W(6)) u_sync (
      .clk(clk),
      .rst(rst),
      .d({pll_areset, pll_configupdate, gxb_pd, rx_analogreset, tx_digitalreset,
          rx_digitalreset}),
      .q(pins_s)
   );
   assign {areset_s, cfgupd_s, pd_s, rxa_s, txd_s, rxd_s} = pins_s;

   // ---------------------------------------------------------------
   // AXI4-Lite slave
   // ---------------------------------------------------------------
   logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
   logic [3:0] awaddr_reg, awaddr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [3:0] wstrb_reg, wstrb_next;
   logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [2:0] mode_reg, mode_next;
   logic chan_sticky_reg, chan_sticky_next, pll_sticky_reg, pll_sticky_next;
   logic wr_do, rd_do, start_req, access_req;
   logic [31:0] status_w;
   logic busy_reg, chan_done_reg, pll_done_reg, locked_reg, freq_reg, pd_reg;

   assign wr_do = aw_hold_reg && w_hold_reg && !bvalid_reg;
   assign rd_do = s_axi_arvalid && !rvalid_reg;
   assign status_w = {25'h0000000, locked_reg && freq_reg && !txd_s && !rxd_s, pll_sticky_reg,
                      chan_sticky_reg, pd_reg, freq_reg, locked_reg, busy_reg};

   always_comb begin
      aw_hold_next = aw_hold_reg;
      w_hold_next = w_hold_reg;
      awaddr_next = awaddr_reg;
      wdata_next = wdata_reg;
      wstrb_next = wstrb_reg;
      bvalid_next = bvalid_reg && !s_axi_bready;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg && !s_axi_rready;
      rresp_next = rresp_reg;
      rdata_next = rdata_reg;
      mode_next = mode_reg;
      chan_sticky_next = chan_sticky_reg;
      pll_sticky_next = pll_sticky_reg;
      start_req = 1'b0;
      access_req = 1'b0;
      if (s_axi_awvalid && !aw_hold_reg) begin
         aw_hold_next = 1'b1;
         awaddr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_reg) begin
         w_hold_next = 1'b1;
         wdata_next = s_axi_wdata;
         wstrb_next = s_axi_wstrb;
      end
      if (wr_do) begin
         aw_hold_next = 1'b0;
         w_hold_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = RESP_OKAY;
         if (awaddr_reg == ADDR_CTRL) begin
            if (wstrb_reg[0]) begin
               mode_next = wdata_reg[CTRL_MODE_LSB +: 3];
            end
            if (wstrb_reg[1] && wdata_reg[CTRL_WALL_BIT]) begin
               start_req = 1'b1;
            end else begin
               access_req = 1'b1;
            end
         end else if (awaddr_reg == ADDR_STATUS) begin
            if (wstrb_reg[0] && wdata_reg[ST_CHAN_DONE]) begin
               chan_sticky_next = 1'b0;
            end
            if (wstrb_reg[0] && wdata_reg[ST_PLL_DONE]) begin
               pll_sticky_next = 1'b0;
            end
         end else begin
            bresp_next = RESP_SLVERR;
         end
      end
      if (rd_do) begin
         rvalid_next = 1'b1;
         rresp_next = RESP_OKAY;
         if (s_axi_araddr == ADDR_CTRL) begin
            rdata_next = {29'h00000000, mode_reg};
            access_req = 1'b1;
         end else if (s_axi_araddr == ADDR_STATUS) begin
            rdata_next = status_w;
         end else begin
            rdata_next = 32'h00000000;
            rresp_next = RESP_SLVERR;
         end
      end
      // A done event in the same cycle as its clear is kept.
      if (chan_done_reg) begin
         chan_sticky_next = 1'b1;
      end
      if (pll_done_reg) begin
         pll_sticky_next = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         awaddr_reg <= 4'h0;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= 32'h00000000;
         mode_reg <= MODE_RST;
         chan_sticky_reg <= 1'b0;
         pll_sticky_reg <= 1'b0;
      end else begin
         aw_hold_reg <= aw_hold_next;
         w_hold_reg <= w_hold_next;
         awaddr_reg <= awaddr_next;
         wdata_reg <= wdata_next;
         wstrb_reg <= wstrb_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rresp_reg <= rresp_next;
         rdata_reg <= rdata_next;
         mode_reg <= mode_next;
         chan_sticky_reg <= chan_sticky_next;
         pll_sticky_reg <= pll_sticky_next;
      end
   end

   assign s_axi_awready = !aw_hold_reg;
   assign s_axi_wready = !w_hold_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;

   // ---------------------------------------------------------------
   // Reconfiguration controller
   // ---------------------------------------------------------------
   // Requests that arrive while busy are answered on the bus but do not restart the
   // controller; software must poll busy before the next write-all.
   ctl_state_t state_reg, state_next;
   logic [15:0] cnt_reg, cnt_next;
   logic busy_next, chan_done_next;

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg + 16'h0001;
      chan_done_next = 1'b0;
      case (state_reg)
         CS_OFFSET: begin
            if (cnt_reg == OFFSET_N - 16'h0001) begin // [RQ17] [RQ20]
               state_next = CS_IDLE;
            end
         end
         CS_IDLE: begin
            cnt_next = 16'h0000;
            if (start_req) begin
               state_next = CS_RECONF; // [RQ9]
            end else if (access_req) begin
               state_next = CS_ACCESS; // [RQ19]
            end
         end
         CS_RECONF: begin
            if (cnt_reg == RECONF_N - 16'h0001) begin
               state_next = CS_IDLE;
               chan_done_next = 1'b1; // [RQ10]
            end
         end
         CS_ACCESS: begin
            if (cnt_reg == ACCESS_N - 16'h0001) begin
               state_next = CS_IDLE;
            end
         end
         default: begin
            state_next = CS_IDLE;
         end
      endcase
      if (state_next != state_reg) begin
         cnt_next = 16'h0000;
      end
      busy_next = (state_next != CS_IDLE); // [RQ9] [RQ19]
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= CS_OFFSET;
         cnt_reg <= 16'h0000;
         busy_reg <= 1'b1;
         chan_done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         busy_reg <= busy_next;
         chan_done_reg <= chan_done_next;
      end
   end

   // ---------------------------------------------------------------
   // PLL scan chain, PLL lock, receiver lock and power-down
   // ---------------------------------------------------------------
   logic cfg_prev_reg, cfg_prev_next, scan_run_reg, scan_run_next, pll_done_next;
   logic [15:0] scan_cnt_reg, scan_cnt_next, lock_cnt_reg, lock_cnt_next;
   logic [15:0] freq_cnt_reg, freq_cnt_next;
   logic locked_next, freq_next, pd_next;

   always_comb begin
      scan_run_next = scan_run_reg;
      scan_cnt_next = scan_cnt_reg;
      pll_done_next = 1'b0;
      cfg_prev_next = cfgupd_s;
      if (cfgupd_s && !cfg_prev_reg && !pd_s) begin
         scan_run_next = 1'b1;
         scan_cnt_next = 16'h0000;
      end else if (scan_run_reg) begin
         scan_cnt_next = scan_cnt_reg + 16'h0001;
         if (scan_cnt_reg == SCAN_N - 16'h0001) begin
            scan_run_next = 1'b0;
            pll_done_next = 1'b1; // [RQ3]
         end
      end
      // Power-down drops every lock at once; PLL reset drops the PLL lock, and the receiver lock one cycle later.
      pd_next = pd_s; // [RQ14]
      locked_next = locked_reg;
      lock_cnt_next = lock_cnt_reg;
      if (pd_s || areset_s) begin
         locked_next = 1'b0; // [RQ3] [RQ14]
         lock_cnt_next = 16'h0000;
      end else if (!locked_reg) begin
         lock_cnt_next = lock_cnt_reg + 16'h0001;
         locked_next = (lock_cnt_reg == LOCK_N - 16'h0001);
      end
      freq_next = freq_reg;
      freq_cnt_next = freq_cnt_reg;
      if (pd_s || rxa_s || !locked_reg) begin
         freq_next = 1'b0; // [RQ14]
         freq_cnt_next = 16'h0000;
      end else if (!freq_reg) begin
         freq_cnt_next = freq_cnt_reg + 16'h0001;
         freq_next = (freq_cnt_reg == FREQ_N - 16'h0001);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_prev_reg <= 1'b0;
         scan_run_reg <= 1'b0;
         scan_cnt_reg <= 16'h0000;
         pll_done_reg <= 1'b0;
         locked_reg <= 1'b0;
         lock_cnt_reg <= 16'h0000;
         freq_reg <= 1'b0;
         freq_cnt_reg <= 16'h0000;
         pd_reg <= 1'b0;
      end else begin
         cfg_prev_reg <= cfg_prev_next;
         scan_run_reg <= scan_run_next;
         scan_cnt_reg <= scan_cnt_next;
         pll_done_reg <= pll_done_next;
         locked_reg <= locked_next;
         lock_cnt_reg <= lock_cnt_next;
         freq_reg <= freq_next;
         freq_cnt_reg <= freq_cnt_next;
         pd_reg <= pd_next;
      end
   end

   assign busy = busy_reg;
   assign channel_reconfig_done = chan_done_reg;
   assign pll_reconfig_done = pll_done_reg;
   assign pll_locked = locked_reg;
   assign rx_freqlocked = freq_reg;
   assign powered_down = pd_reg;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_busy_on_start: assert property (state_reg == CS_IDLE && start_req |=> // [RQ9]
      busy_reg ##0 state_reg == CS_RECONF) else $error("busy did not follow write-all");
   a_reconf_done: assert property (state_reg == CS_RECONF && // [RQ10]
      cnt_reg == RECONF_N - 16'h0001 |=> channel_reconfig_done && !busy ##1
      !channel_reconfig_done) else $error("channel done pulse wrong");
   a_done_cause: assert property ($rose(chan_done_reg) |-> // [RQ10]
      $past(state_reg) == CS_RECONF) else $error("channel done without reconfig");
   a_offset_busy: assert property (state_reg == CS_OFFSET |-> busy) // [RQ17]
      else $error("busy low during offset cancellation");
   a_offset_length: assert property ($fell(busy_reg) && $past(state_reg) == CS_OFFSET |-> // [RQ20]
      $past(cnt_reg) == OFFSET_N - 16'h0001) else $error("offset busy length wrong");
   a_busy_cause: assert property ($rose(busy_reg) |-> // [RQ19]
      $past(start_req) || $past(access_req)) else $error("busy rose without access");
   a_pd_drops: assert property (pd_s |=> powered_down && !pll_locked && !rx_freqlocked) // [RQ14]
      else $error("power-down left block alive");
   a_scan_done: assert property (scan_run_reg && scan_cnt_reg == SCAN_N - 16'h0001 && // [RQ3]
      !cfgupd_s |=> pll_reconfig_done ##1 !pll_reconfig_done)
      else $error("scan done pulse wrong");
   a_areset_unlock: assert property (areset_s |=> !pll_locked) // [RQ3]
      else $error("lock held through PLL reset");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");

   c_reconf: cover property (start_req ##[1:40] channel_reconfig_done);
   c_offset_end: cover property ($fell(busy_reg) ##1 state_reg == CS_IDLE);
   c_scan_lock: cover property (pll_reconfig_done ##[1:200] $rose(pll_locked));
   c_powerdown: cover property ($rose(powered_down));
endmodule

// File: reset_seq_model.sv
// Behavioural model of the user reset logic and PLL reconfiguration controller.
`timescale 1ns/100ps
module reset_seq_model (
   input wire logic clk, // Parallel clock.
   input wire logic busy, // Controller busy.
   input wire logic pll_reconfig_done, // Scan done pulse.
   input wire logic channel_reconfig_done, // Channel done pulse.
   input wire logic pll_locked, // PLL locked.
   input wire logic rx_freqlocked, // Receiver frequency locked.
   output logic pll_areset, // PLL reset.
   output logic pll_configupdate, // Configuration update strobe.
   output logic gxb_pd, // Block power-down.
   output logic tx_digitalreset, // Transmit digital reset.
   output logic rx_analogreset, // Receive analog reset.
   output logic rx_digitalreset // Receive digital reset.
);
   int misses = 0;
   initial begin
      pll_areset = 1'b1;
      pll_configupdate = 1'b0;
      gxb_pd = 1'b0;
      tx_digitalreset = 1'b1;
      rx_analogreset = 1'b1;
      rx_digitalreset = 1'b1;
   end
   // ---------------------------------------------------------------
   // Sequences
   // ---------------------------------------------------------------
   function automatic logic sig(input int w);
      case (w)
         0: return busy;
         1: return pll_reconfig_done;
         2: return channel_reconfig_done;
         3: return pll_locked;
         default: return rx_freqlocked;
      endcase
   endfunction
   // Waits are bounded so that a silent device cannot hang the run.
   task automatic wait_on(input int w, input logic lvl);
      int n;
      for (n = 0; n < 3000 && sig(w) !== lvl; n++) @(negedge clk);
      if (n >= 3000) misses++;
      @(posedge clk);
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic hold_all;
      @(posedge clk);
      tx_digitalreset <= 1'b1;
      rx_analogreset <= 1'b1;
      rx_digitalreset <= 1'b1;
   endtask
   task automatic power_up;
      hold_all();
      pll_areset <= 1'b1;
      cycles(100);
      pll_areset <= 1'b0;
      wait_on(3, 1'b1);
      tx_digitalreset <= 1'b0;
      wait_on(0, 1'b0);
      cycles(2);
      rx_analogreset <= 1'b0;
      wait_on(4, 1'b1);
      rx_digitalreset <= 1'b0;
      cycles(3);
   endtask
   task automatic pll_reconf;
      hold_all();
      cycles(4);
      pll_configupdate <= 1'b1;
      cycles(3);
      pll_configupdate <= 1'b0;
      wait_on(1, 1'b1);
      pll_areset <= 1'b1;
      cycles(100);
      pll_areset <= 1'b0;
      wait_on(3, 1'b1);
      tx_digitalreset <= 1'b0;
      cycles(5);
      rx_analogreset <= 1'b0;
      wait_on(4, 1'b1);
      rx_digitalreset <= 1'b0;
      cycles(3);
   endtask
   task automatic chan_release;
      wait_on(2, 1'b1);
      tx_digitalreset <= 1'b0;
      cycles(5);
      rx_analogreset <= 1'b0;
      wait_on(4, 1'b1);
      rx_digitalreset <= 1'b0;
      cycles(3);
   endtask
   task automatic pd_pulse;
      wait_on(0, 1'b0);
      hold_all();
      gxb_pd <= 1'b1;
      cycles(100);
      gxb_pd <= 1'b0;
      power_up();
   endtask
endmodule

// File: sync2.sv
// Two-flop synchroniser for a bundle of asynchronous pin levels.
`timescale 1ns/100ps
module sync2 #(
   parameter int W = 1
) (
   input wire logic clk, // Parallel clock.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic [W-1:0] d, // Asynchronous levels.
   output logic [W-1:0] q // Synchronised levels.
);
   logic [W-1:0] meta_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

// File: tb_transceiver_reconfig_reset_sequencer.sv
// Self-checking bench for the reconfiguration reset sequencer.
`timescale 1ns/100ps
module tb_transceiver_reconfig_reset_sequencer;
   import reconf_pkg::*;
   logic clk = 1'b0, rst = 1'b1;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, busy, prd, crd, locked, flock, pdn;
   logic areset, cfgup, gxb_pd, ard, tdr, rdr, busy_q = 1'b0, lock_q = 1'b0;
   logic [1:0] bresp, rresp;
   int bad_count = 0, check_count = 0, busy_rises = 0, crd_n = 0, prd_n = 0, lock_falls = 0;
   initial forever #5 clk = ~clk;
   reconf_seq reconf_seq_i (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .pll_areset(areset), .pll_configupdate(cfgup),
      .gxb_pd(gxb_pd), .rx_analogreset(ard), .tx_digitalreset(tdr),
      .rx_digitalreset(rdr), .busy(busy), .pll_reconfig_done(prd),
      .channel_reconfig_done(crd), .pll_locked(locked), .rx_freqlocked(flock),
      .powered_down(pdn));
   reset_seq_model reset_seq_model_i (.clk(clk), .busy(busy), .pll_reconfig_done(prd),
      .channel_reconfig_done(crd), .pll_locked(locked), .rx_freqlocked(flock),
      .pll_areset(areset), .pll_configupdate(cfgup), .gxb_pd(gxb_pd),
      .tx_digitalreset(tdr), .rx_analogreset(ard), .rx_digitalreset(rdr));
   always @(negedge clk) begin
      if (busy === 1'b1 && busy_q !== 1'b1) busy_rises++;
      if (lock_q === 1'b1 && locked === 1'b0) lock_falls++;
      if (crd === 1'b1) crd_n++;
      if (prd === 1'b1) prd_n++;
      busy_q = busy;
      lock_q = locked;
   end
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic chk_rng(input int got, input int lo, input int hi);
      check_count++;
      if (got < lo || got > hi) begin
         bad_count++;
         $display("[FAIL] t=%0t exp=%h..%h got=%h", $time, lo, hi, got);
      end
   endtask
   task automatic hang;
      bad_count++;
      report_and_stop();
   endtask
   // Ready is sampled at the falling edge, where it already shows its rising-edge value.
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                         output logic [1:0] r);
      logic ta, tw, done;
      int n;
      done = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 1000 && !done; n++) begin
         @(negedge clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         done = (bvalid === 1'b1);
         r = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      if (!done) hang();
   endtask
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta, done;
      int n;
      done = 1'b0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 1000 && !done; n++) begin
         @(negedge clk);
         ta = arvalid && arready;
         done = (rvalid === 1'b1);
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      if (!done) hang();
   endtask
   task automatic busy_len(output int n);
      int k;
      n = 0;
      for (k = 0; k < 1000 && busy !== 1'b1; k++) @(negedge clk);
      while (busy === 1'b1 && n < 1000) begin
         @(negedge clk);
         n++;
      end
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      #500000;
      hang();
   end
   initial begin
      int n, c, lf, k;
      logic [31:0] d, seed;
      logic [1:0] r;
      logic [2:0] m;
      seed = 32'h00010D95;
      repeat (2) @(posedge clk);
      chk({busy, prd, crd, locked, flock, pdn, awready, wready, arready}, 9'h107);
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      fork
         busy_len(n);
         reset_seq_model_i.power_up();
      join
      chk_rng(n, int'(OFFSET_CYCLES) - 2, int'(OFFSET_CYCLES) + 2);
      axi_rd(ADDR_STATUS, d, r);
      chk(d, 32'h00000046);
      chk(busy_rises, 1);
      $display("test power_up done");
      for (k = 0; k < 3; k++) begin
         seed = lfsr(seed);
         m = seed[2:0];
         reset_seq_model_i.hold_all();
         c = crd_n;
         fork
            axi_wr(ADDR_CTRL, {23'h0, 1'b1, 5'h0, m}, 4'h3, r);
            busy_len(n);
            reset_seq_model_i.chan_release();
         join
         chk_rng(n, int'(RECONF_CYCLES) - 1, int'(RECONF_CYCLES) + 1);
         chk(crd_n, c + 1);
         chk(r, RESP_OKAY);
         axi_rd(ADDR_STATUS, d, r);
         chk(d, 32'h00000056);
         fork
            axi_rd(ADDR_CTRL, d, r);
            busy_len(n);
         join
         chk(d[2:0], m);
         chk_rng(n, int'(ACCESS_CYCLES) - 1, int'(ACCESS_CYCLES) + 1);
      end
      $display("test channel_reconfig done");
      seed = lfsr(seed);
      c = crd_n;
      fork
         axi_wr(ADDR_CTRL, seed & 32'h00000007, 4'h1, r);
         busy_len(n);
      join
      chk_rng(n, int'(ACCESS_CYCLES) - 1, int'(ACCESS_CYCLES) + 1);
      chk(crd_n, c);
      axi_wr(ADDR_STATUS, 32'h00000030, 4'h1, r);
      c = busy_rises;
      axi_rd(ADDR_STATUS, d, r);
      chk(d, 32'h00000046);
      axi_wr(4'h8, 32'h00000107, 4'h3, r);
      chk(r, RESP_SLVERR);
      axi_rd(4'hC, d, r);
      chk(r, RESP_SLVERR);
      chk(d, 32'h0);
      chk(busy_rises, c);
      $display("test access done");
      k = prd_n;
      lf = lock_falls;
      reset_seq_model_i.pll_reconf();
      chk(prd_n, k + 1);
      chk(lock_falls, lf + 1);
      axi_rd(ADDR_STATUS, d, r);
      chk(d, 32'h00000066);
      $display("test pll_reconfig done");
      fork
         reset_seq_model_i.pd_pulse();
         begin
            repeat (60) @(negedge clk);
            chk({pdn, locked, flock}, 3'h4);
         end
      join
      axi_rd(ADDR_STATUS, d, r);
      chk(d, 32'h00000066);
      chk(busy_rises, c + 0);
      chk(reset_seq_model_i.misses, 0);
      $display("test power_down done");
      report_and_stop();
   end
endmodule
